// >>> src/lpm_pkg.sv
// Package: register map, field positions and timing constants of the low-power mode control
package lpm_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [7:0] LPM_ADDR_STOP_CTRL = 8'h38;
  localparam logic [7:0] LPM_ADDR_CLK_CTRL = 8'h39;
  localparam logic [7:0] LPM_ADDR_TICK_CTRL = 8'h3C;
  localparam logic [7:0] LPM_ADDR_STATUS = 8'h40;
  // stop_mode_control fields
  localparam int LPM_STOP_BIT = 7;
  localparam int LPM_RELEASE_METHOD_BIT_BIT = 6;
  localparam int LPM_RETURN_MODE_BIT_BIT = 5;
  localparam int LPM_PORT_OUTPUT_HOLD_BIT_BIT = 4;
  localparam int LPM_WUT_HI = 3;
  localparam int LPM_WUT_LO = 2;
  // clock_mode_control fields
  localparam int LPM_SYSCK_BIT = 5;
  localparam int LPM_TIMING_GEN_HALT_BIT_BIT = 2;
  // base_tick_control fields
  localparam int LPM_BASE_TICK_ENABLE_BIT = 7;
  localparam int LPM_IMF_BIT = 6;
  localparam int LPM_EF7_BIT = 5;
  localparam int LPM_BASE_TICK_CLOCK_SELECT_HI = 2;
  localparam int LPM_BASE_TICK_CLOCK_SELECT_LO = 0;
  // Reset values
  localparam logic [7:0] LPM_STOP_RESET = 8'h00;
  localparam logic [7:0] LPM_CLK_RESET = 8'h00;
  localparam logic [7:0] LPM_TICK_RESET = 8'h00;
  localparam logic [1:0] LPM_UNDEF_BITS = 2'h0;
  // Warm-up lengths in oscillator periods, indexed by warm-up code
  localparam logic [17:0] LPM_WU_NORM_00 = 18'h30000;
  localparam logic [17:0] LPM_WU_NORM_01 = 18'h10000;
  localparam logic [17:0] LPM_WU_NORM_10 = 18'h0C000;
  localparam logic [17:0] LPM_WU_NORM_11 = 18'h04000;
  localparam logic [17:0] LPM_WU_SLOW_00 = 18'h06000;
  localparam logic [17:0] LPM_WU_SLOW_01 = 18'h02000;
  localparam logic [17:0] LPM_WU_SLOW_10 = 18'h000C0;
  localparam logic [17:0] LPM_WU_SLOW_11 = 18'h00040;
  // Low-frequency machine cycle: four oscillator periods
  localparam logic [1:0] LPM_SLOW_CYCLE_LAST = 2'h3;
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    LPM_NORMAL1 = 6'b000001,
    LPM_NORMAL2 = 6'b000010,
    LPM_SLOW1 = 6'b000100,
    LPM_SLOW2 = 6'b001000,
    LPM_HALT0 = 6'b010000,
    LPM_STOPPED = 6'b100000
  } lpm_mode_e;
  // Stop sequence sub-state, one-hot
  typedef enum logic [2:0] {
    LPM_SQ_RUN = 3'b001,
    LPM_SQ_SLEEP = 3'b010,
    LPM_SQ_WARM = 3'b100
  } lpm_seq_e;
endpackage : lpm_pkg

// >>> src/lpm_ctrl.sv
// Low-power mode controller: halt-to-tick mode, STOP mode and warm-up timing
// Notes on behaviour
// R01 - Halt bit in slow gates all but tick
// R02 - Tick source falling edge regates peripheral clocks
// R03 - Leaving halt mode restarts CPU in SLOW1
// R04 - Halt independent of tick enable; irq needs three
// R05 - Tick enabled at entry sets latch after return
// R06 - STOP turns off oscillators, keeps state
// R07 - Bit 7 written 1 enters STOP
// R08 - Bit 6: 0 edge, 1 level release
// R09 - Warm-up completes, then execution resumes
// R10 - Bit 5 picks NORMAL or SLOW1 return
// R11 - Software sets return bit from source mode
// R12 - Reset release always returns to NORMAL1
// R13 - Bit 4: ports high-Z or held
// R14 - Port inputs forced 0 when not held
// R15 - Wake pin goes high-Z in STOP
// R16 - Warm-up code selects length per return clock
// R17 - Bits 1 and 0 read undefined
// R18 - Key wakeup users choose level release
// R19 - SLOW machine cycle is four slow periods
// R20 - Halt bit self-clears on leaving halt
// R21 - Level release when wake pin high
// R22 - Edge release on wake pin rising edge
// R23 - Warm-up counter cleared at STOP, counts oscillator
// R24 - STOP takes effect after write completes
`timescale 1ns/10ps
module lpm_ctrl
  import lpm_pkg::*;
(
  input wire logic mclk, // 20 MHz system clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [7:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read strobe
  input wire logic avs_write, // Avalon write strobe
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic wake_pin_in, // Stop pin level from pad
  input wire logic tick_src_clk, // Selected tick source clock from the divider
  input wire logic high_freq_tick, // One-cycle pulse per high-frequency period
  input wire logic low_freq_tick, // One-cycle pulse per low-frequency period
  input wire logic base_tick_event, // Tick timer overflow pulse
  input wire logic [7:0] port_in, // Port pad inputs
  input wire logic [7:0] port_latch, // Port output latches
  output logic [7:0] port_out, // Port pad outputs
  output logic [7:0] port_oe_n, // Port output enables, low drives
  output logic wake_pin_oe_n, // Wake pin output enable, low drives
  output logic [7:0] port_in_gated, // Port inputs seen by the core
  output logic cpu_run, // CPU clock running
  output logic periph_clk_en, // Peripheral clocks running
  output logic tick_clk_en, // Tick timer clock running
  output logic hf_osc_en, // High-frequency oscillator on
  output logic lf_osc_en, // Low-frequency oscillator on
  output logic cpu_slow_clk, // CPU running from low-frequency clock
  output logic machine_cycle, // Machine cycle strobe
  output logic base_tick_interrupt // Tick interrupt request level
);
  import lpm_pkg::*;

  logic [7:0] stop_q, stop_d;
  logic [7:0] clkc_q, clkc_d;
  logic [7:0] tick_q;
  lpm_mode_e mode_q, mode_d;
  lpm_seq_e seq_q, seq_d;
  logic [17:0] wu_cnt_q, wu_cnt_d;
  logic [1:0] mc_cnt_q;
  logic pend_stop_q;
  logic tbt_at_entry_q;
  logic irq_latch_q;
  logic wake_s1_q, wake_s2_q, wake_s3_q;
  logic tck_s1_q, tck_s2_q, tck_s3_q;
  logic [7:0] rd_q;
  logic ack_q;
  logic [7:0] port_out_q, port_oe_n_q, port_in_g_q;
  logic wake_oe_n_q, cpu_run_q, periph_q, hf_q, lf_q, slow_q, mc_q;

  // Bus decode: one wait cycle then acknowledge, so every access takes two edges
  wire access = (avs_read || avs_write) && !ack_q;
  wire wr = avs_write && ack_q;
  wire sel_stop = (avs_address == LPM_ADDR_STOP_CTRL);
  wire sel_clk = (avs_address == LPM_ADDR_CLK_CTRL);
  wire sel_tick = (avs_address == LPM_ADDR_TICK_CTRL);
  wire sel_stat = (avs_address == LPM_ADDR_STATUS);
  wire [7:0] wdat = avs_writedata[7:0];
  wire [7:0] rd_mux = sel_stop ? {stop_q[7:2], LPM_UNDEF_BITS} : // [R17]
                      sel_clk ? clkc_q :
                      sel_tick ? tick_q :
                      sel_stat ? {mode_q, irq_latch_q, 1'b0} : 8'h00;

  // Synchronised edges: a change counts while stages two and three differ; the level needs both high
  wire wake_level = wake_s2_q && wake_s3_q;
  wire wake_rise = wake_s2_q && !wake_s3_q;
  wire tck_fall = !tck_s2_q && tck_s3_q;

  // Decode of the stop control fields
  wire release_method_bit = stop_q[LPM_RELEASE_METHOD_BIT_BIT];
  wire return_mode_bit = stop_q[LPM_RETURN_MODE_BIT_BIT];
  wire port_output_hold_bit = stop_q[LPM_PORT_OUTPUT_HOLD_BIT_BIT];
  wire [1:0] warmup_time_field = stop_q[LPM_WUT_HI:LPM_WUT_LO];
  // Reset clears the return bit, so a reset-ended STOP always comes back in NORMAL1
  wire slow_ret = return_mode_bit;
  wire release_ok = release_method_bit ? wake_level : wake_rise; // [R08] [R21] [R22]
  wire osc_tick = slow_ret ? low_freq_tick : high_freq_tick; // [R23]
  wire [17:0] wu_norm = (warmup_time_field == 2'h0) ? LPM_WU_NORM_00 : (warmup_time_field == 2'h1) ? LPM_WU_NORM_01 :
                        (warmup_time_field == 2'h2) ? LPM_WU_NORM_10 : LPM_WU_NORM_11;
  wire [17:0] wu_slow = (warmup_time_field == 2'h0) ? LPM_WU_SLOW_00 : (warmup_time_field == 2'h1) ? LPM_WU_SLOW_01 :
                        (warmup_time_field == 2'h2) ? LPM_WU_SLOW_10 : LPM_WU_SLOW_11;
  wire [17:0] wu_len = slow_ret ? wu_slow : wu_norm; // [R16]
  wire wu_done = (wu_cnt_q >= wu_len);
  wire in_slow = (mode_q == LPM_SLOW1) || (mode_q == LPM_SLOW2);
  wire halt_go = in_slow && clkc_q[LPM_TIMING_GEN_HALT_BIT_BIT]; // [R01]
  wire tbt_en = tick_q[LPM_BASE_TICK_ENABLE_BIT];
  wire irq_ok = tick_q[LPM_IMF_BIT] && tick_q[LPM_EF7_BIT] && tbt_en; // [R04]

  // Next mode and stop sequence
  always_comb begin
    mode_d = mode_q;
    seq_d = seq_q;
    wu_cnt_d = wu_cnt_q;
    stop_d = stop_q;
    clkc_d = clkc_q;
    if (wr && sel_stop) stop_d = wdat;
    if (wr && sel_clk) clkc_d = wdat;
    unique case (mode_q)
      LPM_NORMAL1, LPM_NORMAL2, LPM_SLOW1, LPM_SLOW2: begin
        // Only a NORMAL mode moves to SLOW2, so a halt return keeps SLOW1
        mode_d = (clkc_d[LPM_SYSCK_BIT] && !in_slow) ? LPM_SLOW2 : mode_q;
        if (halt_go) mode_d = LPM_HALT0; // [R01]
        else if (pend_stop_q) begin
          mode_d = LPM_STOPPED; // [R07] [R24]
          wu_cnt_d = 18'h0; // [R23]
          seq_d = (release_method_bit && wake_level) ? LPM_SQ_WARM : LPM_SQ_SLEEP;
        end
      end
      LPM_HALT0: begin
        if (tck_fall) begin
          mode_d = LPM_SLOW1; // [R02] [R03]
          clkc_d[LPM_TIMING_GEN_HALT_BIT_BIT] = 1'b0; // [R20]
        end
      end
      LPM_STOPPED: begin
        unique case (seq_q)
          LPM_SQ_SLEEP: if (release_ok) seq_d = LPM_SQ_WARM;
          LPM_SQ_WARM: begin
            if (wu_done) begin
              seq_d = LPM_SQ_RUN; // [R09]
              stop_d[LPM_STOP_BIT] = 1'b0;
              mode_d = slow_ret ? LPM_SLOW1 : LPM_NORMAL1; // [R10] [R11]
            end else if (osc_tick) wu_cnt_d = wu_cnt_q + 18'h1; // [R23]
          end
          LPM_SQ_RUN: seq_d = LPM_SQ_RUN;
        endcase
      end
    endcase
  end

  // Control state and bus registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      stop_q <= LPM_STOP_RESET;
      clkc_q <= LPM_CLK_RESET;
      tick_q <= LPM_TICK_RESET;
      mode_q <= LPM_NORMAL1; // [R12]
      seq_q <= LPM_SQ_RUN;
      wu_cnt_q <= 18'h0;
      ack_q <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      stop_q <= stop_d;
      clkc_q <= clkc_d;
      if (wr && sel_tick) tick_q <= wdat;
      mode_q <= mode_d;
      seq_q <= seq_d;
      wu_cnt_q <= wu_cnt_d;
      ack_q <= access;
      if (access) rd_q <= rd_mux;
    end
  end

  // Stop request armed by the completed write
  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_stop_q <= 1'b0;
    end else begin
      pend_stop_q <= wr && sel_stop && wdat[LPM_STOP_BIT]; // [R24]
    end
  end

  // Tick latch: set wins over clear by software write
  always_ff @(posedge mclk) begin
    if (reset) begin
      tbt_at_entry_q <= 1'b0;
      irq_latch_q <= 1'b0;
    end else begin
      if (mode_q != LPM_HALT0) tbt_at_entry_q <= tbt_en;
      if ((mode_q == LPM_HALT0 && tck_fall && tbt_at_entry_q) || // [R05]
          (base_tick_event && tbt_en))
        irq_latch_q <= 1'b1;
      else if (wr && sel_stat)
        irq_latch_q <= 1'b0;
    end
  end

  // Three-stage synchronisers for the wake pin and tick source clock
  always_ff @(posedge mclk) begin
    if (reset) begin
      {wake_s1_q, wake_s2_q, wake_s3_q} <= 3'h0;
      {tck_s1_q, tck_s2_q, tck_s3_q} <= 3'h0;
    end else begin
      {wake_s1_q, wake_s2_q, wake_s3_q} <= {wake_pin_in, wake_s1_q, wake_s2_q};
      {tck_s1_q, tck_s2_q, tck_s3_q} <= {tick_src_clk, tck_s1_q, tck_s2_q};
    end
  end

  // Machine cycle divider: in slow modes one strobe per four slow periods
  always_ff @(posedge mclk) begin
    if (reset) mc_cnt_q <= 2'h0;
    else if (in_slow ? low_freq_tick : high_freq_tick) mc_cnt_q <= mc_cnt_q + 2'h1; // [R19]
  end

  // Registered outputs; the mode decides clocks, oscillators and pads
  wire stopped = (mode_q == LPM_STOPPED);
  wire asleep = stopped && (seq_q == LPM_SQ_SLEEP);
  always_ff @(posedge mclk) begin
    if (reset) begin
      port_out_q <= 8'h00;
      port_oe_n_q <= 8'hFF;
      port_in_g_q <= 8'h00;
      wake_oe_n_q <= 1'b1;
      cpu_run_q <= 1'b0;
      periph_q <= 1'b0;
      hf_q <= 1'b0;
      lf_q <= 1'b0;
      slow_q <= 1'b0;
      mc_q <= 1'b0;
    end else begin
      port_out_q <= port_latch; // [R06]
      port_oe_n_q <= (stopped && !port_output_hold_bit) ? 8'hFF : 8'h00; // [R13]
      port_in_g_q <= (stopped && !port_output_hold_bit) ? 8'h00 : port_in; // [R14]
      wake_oe_n_q <= 1'b1; // [R15]
      cpu_run_q <= !stopped && (mode_q != LPM_HALT0); // [R01] [R06]
      periph_q <= !stopped && (mode_q != LPM_HALT0); // [R02]
      hf_q <= !asleep && !in_slow && !(stopped && slow_ret); // [R06]
      lf_q <= !asleep;
      slow_q <= in_slow; // [R19]
      mc_q <= (in_slow ? low_freq_tick : high_freq_tick) && (mc_cnt_q == LPM_SLOW_CYCLE_LAST);
    end
  end

  assign avs_readdata = {24'h000000, rd_q};
  assign avs_waitrequest = !ack_q;
  assign port_out = port_out_q;
  assign port_oe_n = port_oe_n_q;
  assign port_in_gated = port_in_g_q;
  assign wake_pin_oe_n = wake_oe_n_q;
  assign cpu_run = cpu_run_q;
  assign periph_clk_en = periph_q;
  assign tick_clk_en = lf_q || hf_q;
  assign hf_osc_en = hf_q;
  assign lf_osc_en = lf_q;
  assign cpu_slow_clk = slow_q;
  assign machine_cycle = mc_q;
  assign base_tick_interrupt = irq_latch_q && irq_ok; // [R04]
endmodule : lpm_ctrl

// >>> verif/lpm_ctrl_asserts.sv
// Checker: port-level properties of the low-power mode controller
`timescale 1ns/10ps
module lpm_ctrl_asserts
  import lpm_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic reset, // Reset
  input wire logic [7:0] avs_address, // Bus
  input wire logic avs_read, // Bus
  input wire logic avs_write, // Bus
  input wire logic [31:0] avs_writedata, // Bus
  input wire logic [31:0] avs_readdata, // Bus
  input wire logic avs_waitrequest, // Bus
  input wire logic tick_src_clk, // Tick source
  input wire logic [7:0] port_oe_n, // Ports
  input wire logic [7:0] port_in_gated, // Ports
  input wire logic wake_pin_oe_n, // Wake pin
  input wire logic cpu_run, // Clocks
  input wire logic periph_clk_en, // Clocks
  input wire logic tick_clk_en, // Clocks
  input wire logic hf_osc_en, // Clocks
  input wire logic lf_osc_en, // Clocks
  input wire logic cpu_slow_clk, // Clocks
  input wire logic machine_cycle // Clocks
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  localparam int WARM_MIN = 64;
  logic rst_q, seen_q;
  logic [17:0] warm_q;
  wire stopped = !cpu_run && !hf_osc_en && !lf_osc_en;
  // Warm-up tracker; the edge after reset is skipped so start-up is not taken for a wake
  always_ff @(posedge mclk) begin
    rst_q <= reset;
    seen_q <= reset ? 1'b0 : (stopped && !rst_q) ? 1'b1 : cpu_run ? 1'b0 : seen_q;
    warm_q <= stopped ? 18'h0 : (!cpu_run && !(&warm_q)) ? warm_q + 18'h1 : warm_q;
  end
  sequence s_stop_wr;
    avs_write && !avs_waitrequest && avs_address == LPM_ADDR_STOP_CTRL
      && avs_writedata[LPM_STOP_BIT] && !avs_writedata[LPM_RELEASE_METHOD_BIT_BIT];
  endsequence
  sequence s_all_off;
    !cpu_run && !hf_osc_en && !lf_osc_en;
  endsequence
  a_stop_enter: assert property (s_stop_wr |-> ##[1:4] s_all_off)
    else $error("stop not entered");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  a_read_undef: assert property (avs_read && !avs_waitrequest
    && avs_address == LPM_ADDR_STOP_CTRL |-> avs_readdata[1:0] == LPM_UNDEF_BITS)
    else $error("undefined bits set");
  a_wake_hiz: assert property (wake_pin_oe_n) else $error("wake pin driven");
  a_hiz_gated: assert property (stopped && port_oe_n == 8'hFF |-> port_in_gated == 8'h00)
    else $error("inputs not forced");
  a_regate_tick: assert property ($fell(tick_src_clk) && !periph_clk_en && tick_clk_en
    |-> ##[1:6] periph_clk_en) else $error("no regate");
  a_halt_restart: assert property ($rose(periph_clk_en) |-> ##[0:3] cpu_run)
    else $error("cpu not restarted");
  a_warm_min: assert property ($rose(cpu_run) && seen_q |-> warm_q >= WARM_MIN)
    else $error("warm-up short");
  a_slow_cycle: assert property ((cpu_slow_clk && cpu_run)[*5] ##0 machine_cycle
    |-> $past(machine_cycle, 4) && !$past(machine_cycle)) else $error("slow cycle");
endmodule : lpm_ctrl_asserts

// >>> verif/lpm_wake_src.sv
// Partner: external wake source on the stop pin
`timescale 1ns/10ps
module lpm_wake_src (
  input wire logic mclk, // Clock
  input wire logic go, // Start a wake pulse
  output logic wake // Stop pin level
);
  int cnt = 0;
  initial wake = 1'b0;
  // Pulse long enough to pass the pin synchroniser, low again so edge mode sees a fresh rise
  always @(posedge mclk) begin
    if (go) cnt <= 1;
    else if (cnt != 0) cnt <= (cnt == 12) ? 0 : cnt + 1;
    wake <= (cnt >= 5);
  end
endmodule : lpm_wake_src

// >>> verif/lpm_ctrl_tb_top.sv
// Testbench: register access, halt mode and STOP entry and release
`timescale 1ns/10ps
module lpm_ctrl_tb_top;
  import lpm_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic wake_go = 1'b0, tick_src_clk = 1'b0;
  logic [7:0] avs_address = 8'h00, rd;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, wake_pin_in, wake_pin_oe_n, cpu_run, periph_clk_en, tick_clk_en;
  logic hf_osc_en, lf_osc_en, cpu_slow_clk, machine_cycle, base_tick_interrupt;
  logic [7:0] port_out, port_oe_n, port_in_gated;
  int err_total = 0, samples_checked = 0, n;
  lpm_ctrl dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wake_pin_in(wake_pin_in), .tick_src_clk(tick_src_clk),
    .high_freq_tick(1'b1), .low_freq_tick(1'b1), .base_tick_event(1'b0), .port_in(8'hA5),
    .port_latch(8'h5A), .port_out(port_out), .port_oe_n(port_oe_n),
    .wake_pin_oe_n(wake_pin_oe_n), .port_in_gated(port_in_gated), .cpu_run(cpu_run),
    .periph_clk_en(periph_clk_en), .tick_clk_en(tick_clk_en), .hf_osc_en(hf_osc_en),
    .lf_osc_en(lf_osc_en), .cpu_slow_clk(cpu_slow_clk), .machine_cycle(machine_cycle),
    .base_tick_interrupt(base_tick_interrupt));
  lpm_wake_src u_wake (.mclk(mclk), .go(wake_go), .wake(wake_pin_in));
  initial forever #25 mclk = ~mclk;
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Master holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin @(posedge mclk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("bus answer", k < 50, 1'b1);
  endtask : bus
  task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, e);
  endtask : rdc
  task do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
  endtask : do_reset
  // Enter STOP, look at the pins, wake through the partner, time the warm-up
  task do_stop(input logic [7:0] ctrl, input int wmin, input logic [7:0] mode);
    bus(1'b1, LPM_ADDR_STOP_CTRL, ctrl);
    repeat (4) @(negedge mclk);
    chk("cpu_run", cpu_run, 1'b0);
    chk("osc", {hf_osc_en, lf_osc_en}, 2'b00);
    chk("wake oe", wake_pin_oe_n, 1'b1);
    if (ctrl[LPM_PORT_OUTPUT_HOLD_BIT_BIT]) chk("port out", port_out, 8'h5A);
    else chk("port hiz", {port_oe_n, port_in_gated}, 16'hFF00);
    @(posedge mclk);
    wake_go <= 1'b1;
    @(posedge mclk);
    wake_go <= 1'b0;
    n = 0;
    while (cpu_run !== 1'b1 && n < 40000) begin @(posedge mclk); n++; end
    chk("warm-up", n >= wmin && n <= wmin + 20, 1'b1);
    rdc(LPM_ADDR_STATUS, mode, "return mode");
  endtask : do_stop
  task t_regs;
    rdc(LPM_ADDR_STOP_CTRL, LPM_STOP_RESET, "stop reset");
    rdc(LPM_ADDR_STATUS, 8'h04, "normal1");
    rdc(8'h20, 8'h00, "unmapped");
    bus(1'b1, LPM_ADDR_STOP_CTRL, 8'h3F);
    rdc(LPM_ADDR_STOP_CTRL, 8'h3C, "low bits");
    bus(1'b1, LPM_ADDR_STOP_CTRL, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task t_halt;
    bus(1'b1, LPM_ADDR_TICK_CTRL, 8'hE0);
    bus(1'b1, LPM_ADDR_CLK_CTRL, 8'h20);
    rdc(LPM_ADDR_STATUS, 8'h20, "slow2");
    bus(1'b1, LPM_ADDR_CLK_CTRL, 8'h24);
    repeat (4) @(negedge mclk);
    chk("halt gating", {cpu_run, periph_clk_en, tick_clk_en}, 3'b001);
    @(posedge mclk);
    tick_src_clk <= 1'b1;
    repeat (8) @(negedge mclk);
    chk("rise ignored", periph_clk_en, 1'b0);
    @(posedge mclk);
    tick_src_clk <= 1'b0;
    n = 0;
    while (periph_clk_en !== 1'b1 && n < 20) begin @(posedge mclk); n++; end
    chk("regate", periph_clk_en, 1'b1);
    rdc(LPM_ADDR_STATUS, 8'h12, "slow1 latch");
    chk("tick irq", base_tick_interrupt, 1'b1);
    bus(1'b0, LPM_ADDR_CLK_CTRL, 8'h00);
    chk("halt bit", rd[LPM_TIMING_GEN_HALT_BIT_BIT], 1'b0);
    bus(1'b1, LPM_ADDR_STATUS, 8'h00);
    repeat (2) @(negedge mclk);
    chk("irq cleared", base_tick_interrupt, 1'b0);
    $display("t_halt done");
  endtask : t_halt
  task t_stop_slow;
    do_stop(8'hAC, 64, 8'h10);
    do_stop(8'hF8, 192, 8'h10);
    $display("t_stop_slow done");
  endtask : t_stop_slow
  task t_reset_stop;
    bus(1'b1, LPM_ADDR_STOP_CTRL, 8'h8C);
    repeat (4) @(negedge mclk);
    do_reset();
    rdc(LPM_ADDR_STATUS, 8'h04, "reset return");
    do_stop(8'h8C, 16384, 8'h04);
    $display("t_reset_stop done");
  endtask : t_reset_stop
  initial begin
    do_reset();
    t_regs();
    t_halt();
    t_stop_slow();
    t_reset_stop();
    end_of_test();
  end
  initial begin
    #2500000;
    err_total++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : lpm_ctrl_tb_top
bind lpm_ctrl lpm_ctrl_asserts u_chk (.mclk(mclk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tick_src_clk(tick_src_clk),
  .port_oe_n(port_oe_n), .port_in_gated(port_in_gated), .wake_pin_oe_n(wake_pin_oe_n),
  .cpu_run(cpu_run), .periph_clk_en(periph_clk_en), .tick_clk_en(tick_clk_en),
  .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en), .cpu_slow_clk(cpu_slow_clk),
  .machine_cycle(machine_cycle));
